// ==== rtl/pvic_defs.svh ====
/*
 * constants of the prioritised vectored interrupt controller: register
 * indices, field positions, reset values and cycle counts.
 * assumes it is included by the package and by the bench only.
 */
`ifndef PVIC_DEFS_SVH
`define PVIC_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define PVIC_IDX_CLR0      10'h0da
`define PVIC_IDX_CLR1      10'h0db
`define PVIC_IDX_CLR2      10'h0dc
`define PVIC_IDX_MSK3      10'h0de
`define PVIC_IDX_MSK2      10'h0df
`define PVIC_IDX_MSK0      10'h0e0
`define PVIC_IDX_MSK1      10'h0e1
`define PVIC_IDX_STAT      10'h0e4

// ==========================================================
// fields and reset values
`define PVIC_SWPOST_BIT    7
`define PVIC_SRC_VALID     24'h3fffff
`define PVIC_FLAG_RST      24'h000000
`define PVIC_BYTE_RST      8'h00
`define PVIC_USB_IDLE      2'b01
`define PVIC_DATA_RST      32'h00000000
`define PVIC_PRIO_NONE     5'h00
`define PVIC_PRIO_TOP      25
`define PVIC_RSV_LO        22
`define PVIC_RSV_HI        24

// flat source bit of the dedicated event logic
`define PVIC_BIT_GPIO0     4
`define PVIC_BIT_GPIO1     7
`define PVIC_BIT_USBACT    12
`define PVIC_BIT_PS2       19
`define PVIC_BIT_GPIO2     20
`define PVIC_BIT_GPIO3     21

// ==========================================================
// cycle counts
`define PVIC_DISPATCH_CYC  4'hd
`define PVIC_LONG_JUMP_OP_CYC      4'h7
`define PVIC_PS2_LOW_TICKS 3'h6
`define PVIC_CNT_ZERO      4'h0
`define PVIC_CNT_ONE       4'h1

`endif

// ==== rtl/pvic_pkg.sv ====
/*
 * types of the prioritised vectored interrupt controller.
 * assumes the constants header sits beside it.
 */
`include "pvic_defs.svh"

package pvic_pkg;

    // ==========================================================
    // dispatch sequencer
    typedef enum logic [1:0] {
        PVIC_ST_IDLE = 2'b00,
        PVIC_ST_DISP = 2'b01,
        PVIC_ST_JUMP = 2'b10
    } pvic_state_t;

endpackage : pvic_pkg

// ==== rtl/pvic_ctrl.sv ====
/*
 * prioritised vectored interrupt controller with apb register slave,
 * source posting, masking, priority encoding and dispatch sequencing.
 * assumes the cpu core and peripheral event pulses run on clock; gpio,
 * usb line, ps/2 pad and 32 khz clock pins are asynchronous.
 */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - sources ordered by priority 1..25, one highest, fixed source list.
// - vector addresses four bytes apart, 0004h up to 0064h.
// - a source trigger sets its posted flag.
// - posted flag holds until taken or cleared by software.
// - posted source is pending only while its mask bit is set.
// - mask bit never clears nor blocks posting, only gates pending.
// - encoder picks highest pending; taken only while global enable set.
// - request goes active on trigger, unmask, or global enable rising.
// - dispatch waits for the current instruction to finish.
// - dispatch lasts 13 cycles, pushing pc high, pc low, flags.
// - after stacking the flag register clears, blocking interrupts.
// - pc high byte zeroed, low byte loaded with the vector.
// - return restores pc and flags, re-enabling interrupts.
// - after a return, pending requests dispatch before the next instruction.
// - usb activity triggers when lines leave idle: k or se0.
// - ps/2 low triggers after 6 low 32 khz ticks as input.
// - gpio port sources post on edges, not levels.
// - latency is remaining instruction plus 13 plus 7 cycles.
// - reading a clear register returns the posted flags.
// - software post off: write zero clears, write one ignored.
// - software post on: write one posts, write zero ignored.
module pvic_ctrl
    import pvic_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // peripheral events and pins
    input  wire logic [23:0] srcEvent,
    input  wire logic [3:0]  gpioPin,
    input  wire logic        usbDp,
    input  wire logic        usbDm,
    input  wire logic        ps2DataPad,
    input  wire logic        ps2PadIsInput,
    input  wire logic        clk32k,
    // cpu core
    input  wire logic        globalIrqEnable,
    input  wire logic        instrDone,
    input  wire logic        returnFromIrqOp,
    output logic             irqRequest,
    output logic             dispatchBusy,
    output logic             pushPcHigh,
    output logic             pushPcLow,
    output logic             pushFlags,
    output logic             clearFlags,
    output logic             loadVector,
    output logic [7:0]       vectorLow,
    output logic             isrEntry
);

    // ==========================================================
    // decode helpers
    function automatic logic [4:0] prioBit(input logic [4:0] p);
        case (p)
            5'h01: prioBit = 5'h00;
            5'h02: prioBit = 5'h01;
            5'h03: prioBit = 5'h02;
            5'h04: prioBit = 5'h03;
            5'h05: prioBit = 5'h04;
            5'h06: prioBit = 5'h07;
            5'h07: prioBit = 5'h05;
            5'h19: prioBit = 5'h06;
            default: prioBit = p;
        endcase
    endfunction : prioBit

    // lowest number wins, so scan down from PVIC_PRIO_TOP (25) to 1 and keep the last hit
    function automatic logic [4:0] pickPrio(input logic [23:0] pend);
        logic [4:0] best;
        best = `PVIC_PRIO_NONE;
        for (int p = `PVIC_PRIO_TOP; p >= 1; p--) begin
            if ((p < `PVIC_RSV_LO || p > `PVIC_RSV_HI) && pend[prioBit(5'(p))]) begin
                best = 5'(p);
            end
        end
        return best;
    endfunction : pickPrio

    function automatic logic isMapped(input logic [9:0] idx);
        case (idx)
            `PVIC_IDX_CLR0, `PVIC_IDX_CLR1, `PVIC_IDX_CLR2, `PVIC_IDX_MSK0,
            `PVIC_IDX_MSK1, `PVIC_IDX_MSK2, `PVIC_IDX_MSK3,
            `PVIC_IDX_STAT: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction : isMapped

    // ==========================================================
    // state
    logic [23:0]  posted_r;
    logic [23:0]  posted_nxt;
    logic [23:0]  mask_r;
    logic         swPostEnable_r;
    pvic_state_t  state_r;
    logic [3:0]   cnt_r;
    logic [4:0]   selPrio_r;
    logic         retPending_r;
    logic [3:0]   gpioS1_r;
    logic [3:0]   gpioS2_r;
    logic [3:0]   gpioS3_r;
    logic [1:0]   usbS1_r;
    logic [1:0]   usbS2_r;
    logic         usbBusy_r;
    logic         ps2S1_r;
    logic         ps2S2_r;
    logic [2:0]   slowS_r;
    logic [2:0]   ps2Cnt_r;
    logic [23:0]  hwSet;
    logic [23:0]  swPost;
    logic [23:0]  swClear;
    logic [23:0]  ackClr;
    logic [23:0]  wrBits;
    logic [23:0]  pending;
    logic [4:0]   pickNow;
    logic         usbNonIdle;
    logic         ps2Hit;
    logic         slowTick;
    logic         apbWrite;
    logic         takeNow;
    logic [9:0]   regIdx;

    assign regIdx = paddr[11:2];
    assign apbWrite = psel && penable && pready && pwrite && !pslverr;

    // ==========================================================
    // pin synchronisers and dedicated triggers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gpioS1_r <= 4'h0;
            gpioS2_r <= 4'h0;
            gpioS3_r <= 4'h0;
            // start at idle j, or the release of reset would post usb activity
            usbS1_r  <= `PVIC_USB_IDLE;
            usbS2_r  <= `PVIC_USB_IDLE;
            usbBusy_r <= 1'b0;
            ps2S1_r  <= 1'b1;
            ps2S2_r  <= 1'b1;
            slowS_r  <= 3'h0;
        end else begin
            gpioS1_r <= gpioPin;
            gpioS2_r <= gpioS1_r;
            gpioS3_r <= gpioS2_r;
            usbS1_r  <= {usbDp, usbDm};
            usbS2_r  <= usbS1_r;
            usbBusy_r <= usbNonIdle;
            ps2S1_r  <= ps2DataPad;
            ps2S2_r  <= ps2S1_r;
            slowS_r  <= {slowS_r[1:0], clk32k};
        end
    end

    // low speed idle is j: d+ low, d- high; anything else is k or se0
    assign usbNonIdle = (usbS2_r != `PVIC_USB_IDLE);
    // the 32 khz clock is only sampled, so its edges cost no second domain
    assign slowTick = slowS_r[1] && !slowS_r[2];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ps2Cnt_r <= 3'h0;
        end else if (ps2S2_r || !ps2PadIsInput) begin
            ps2Cnt_r <= 3'h0;
        end else if (slowTick && ps2Cnt_r != `PVIC_PS2_LOW_TICKS) begin
            ps2Cnt_r <= ps2Cnt_r + 3'h1;
        end
    end

    // posts once per low spell, on the tick that reaches the count
    assign ps2Hit = slowTick && !ps2S2_r && ps2PadIsInput
                    && (ps2Cnt_r == `PVIC_PS2_LOW_TICKS - 3'h1);

    always_comb begin
        hwSet = srcEvent;
        hwSet[`PVIC_BIT_GPIO0]  = srcEvent[`PVIC_BIT_GPIO0] | (gpioS2_r[0] ^ gpioS3_r[0]);
        hwSet[`PVIC_BIT_GPIO1]  = srcEvent[`PVIC_BIT_GPIO1] | (gpioS2_r[1] ^ gpioS3_r[1]);
        hwSet[`PVIC_BIT_GPIO2]  = srcEvent[`PVIC_BIT_GPIO2] | (gpioS2_r[2] ^ gpioS3_r[2]);
        hwSet[`PVIC_BIT_GPIO3]  = srcEvent[`PVIC_BIT_GPIO3] | (gpioS2_r[3] ^ gpioS3_r[3]);
        hwSet[`PVIC_BIT_USBACT] = srcEvent[`PVIC_BIT_USBACT] | (usbNonIdle && !usbBusy_r);
        hwSet[`PVIC_BIT_PS2]    = srcEvent[`PVIC_BIT_PS2] | ps2Hit;
        hwSet = hwSet & `PVIC_SRC_VALID;
    end

    // ==========================================================
    // posted flags
    always_comb begin
        wrBits = `PVIC_FLAG_RST;
        case (regIdx)
            `PVIC_IDX_CLR0: wrBits = {16'h0, pwdata[7:0]};
            `PVIC_IDX_CLR1: wrBits = {8'h0, pwdata[7:0], 8'h0};
            `PVIC_IDX_CLR2: wrBits = {pwdata[7:0], 16'h0};
            default: wrBits = `PVIC_FLAG_RST;
        endcase
    end

    always_comb begin
        swPost  = `PVIC_FLAG_RST;
        swClear = `PVIC_FLAG_RST;
        if (apbWrite && (regIdx == `PVIC_IDX_CLR0 || regIdx == `PVIC_IDX_CLR1
                         || regIdx == `PVIC_IDX_CLR2)) begin
            if (swPostEnable_r) begin
                swPost = wrBits & `PVIC_SRC_VALID;
            end else begin
                swClear = ~wrBits & `PVIC_SRC_VALID;
                case (regIdx)
                    `PVIC_IDX_CLR0: swClear[23:8] = 16'h0;
                    `PVIC_IDX_CLR1: swClear = {8'h0, swClear[15:8], 8'h0};
                    default: swClear[15:0] = 16'h0;
                endcase
            end
        end
    end

    // set wins over either clear, so an event in the clearing cycle stays
    assign ackClr = takeNow ? (24'h1 << prioBit(pickNow)) : `PVIC_FLAG_RST;
    assign posted_nxt = ((posted_r & ~swClear & ~ackClr) | hwSet | swPost)
                        & `PVIC_SRC_VALID;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            posted_r <= `PVIC_FLAG_RST;
        end else begin
            posted_r <= posted_nxt;
        end
    end

    assign pending = posted_r & mask_r;
    assign pickNow = pickPrio(pending);

    // ==========================================================
    // mask and control registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mask_r         <= `PVIC_FLAG_RST;
            swPostEnable_r <= 1'b0;
        end else if (apbWrite) begin
            case (regIdx)
                `PVIC_IDX_MSK0: mask_r[7:0]   <= pwdata[7:0];
                `PVIC_IDX_MSK1: mask_r[15:8]  <= pwdata[7:0];
                `PVIC_IDX_MSK2: mask_r[23:16] <= pwdata[7:0] & 8'h3f;
                `PVIC_IDX_MSK3: swPostEnable_r <= pwdata[`PVIC_SWPOST_BIT];
                default: mask_r <= mask_r;
            endcase
        end
    end

    // ==========================================================
    // apb slave: zero wait states, pready in the first access cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PVIC_DATA_RST;
        end else if (psel && !penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !isMapped(regIdx);
            case (regIdx)
                `PVIC_IDX_CLR0: prdata <= {24'h0, posted_r[7:0]};
                `PVIC_IDX_CLR1: prdata <= {24'h0, posted_r[15:8]};
                `PVIC_IDX_CLR2: prdata <= {24'h0, posted_r[23:16]};
                `PVIC_IDX_MSK0: prdata <= {24'h0, mask_r[7:0]};
                `PVIC_IDX_MSK1: prdata <= {24'h0, mask_r[15:8]};
                `PVIC_IDX_MSK2: prdata <= {24'h0, mask_r[23:16]};
                `PVIC_IDX_MSK3: prdata <= {24'h0, swPostEnable_r, 7'h0};
                `PVIC_IDX_STAT: prdata <= {16'h0, state_r, 1'b0, selPrio_r, 3'h0, pickNow};
                default: prdata <= `PVIC_DATA_RST;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PVIC_DATA_RST;
        end
    end

    // ==========================================================
    // dispatch sequencer
    // a return lets a pending request in without waiting for an instruction
    assign takeNow = (state_r == PVIC_ST_IDLE) && globalIrqEnable
                     && (pickNow != `PVIC_PRIO_NONE)
                     && (instrDone || retPending_r);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            retPending_r <= 1'b0;
        end else if (takeNow || instrDone) begin
            retPending_r <= 1'b0;
        end else if (returnFromIrqOp) begin
            retPending_r <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r   <= PVIC_ST_IDLE;
            cnt_r     <= `PVIC_CNT_ZERO;
            selPrio_r <= `PVIC_PRIO_NONE;
        end else begin
            case (state_r)
                PVIC_ST_IDLE: begin
                    cnt_r <= `PVIC_CNT_ZERO;
                    if (takeNow) begin
                        state_r   <= PVIC_ST_DISP;
                        selPrio_r <= pickNow;
                    end
                end
                PVIC_ST_DISP: begin
                    if (cnt_r == `PVIC_DISPATCH_CYC - `PVIC_CNT_ONE) begin
                        state_r <= PVIC_ST_JUMP;
                        cnt_r   <= `PVIC_CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r + `PVIC_CNT_ONE;
                    end
                end
                PVIC_ST_JUMP: begin
                    if (cnt_r == `PVIC_LONG_JUMP_OP_CYC - `PVIC_CNT_ONE) begin
                        state_r <= PVIC_ST_IDLE;
                        cnt_r   <= `PVIC_CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r + `PVIC_CNT_ONE;
                    end
                end
                default: begin
                    state_r <= PVIC_ST_IDLE;
                    cnt_r   <= `PVIC_CNT_ZERO;
                end
            endcase
        end
    end

    // strobes trail the sequencer count by one cycle so they leave flops
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pushPcHigh   <= 1'b0;
            pushPcLow    <= 1'b0;
            pushFlags    <= 1'b0;
            clearFlags   <= 1'b0;
            loadVector   <= 1'b0;
            isrEntry     <= 1'b0;
            dispatchBusy <= 1'b0;
            irqRequest   <= 1'b0;
            vectorLow    <= `PVIC_BYTE_RST;
        end else begin
            pushPcHigh   <= (state_r == PVIC_ST_DISP) && (cnt_r == 4'h0);
            pushPcLow    <= (state_r == PVIC_ST_DISP) && (cnt_r == 4'h1);
            pushFlags    <= (state_r == PVIC_ST_DISP) && (cnt_r == 4'h2);
            clearFlags   <= (state_r == PVIC_ST_DISP) && (cnt_r == 4'h3);
            loadVector   <= (state_r == PVIC_ST_DISP) && (cnt_r == 4'h4);
            isrEntry     <= (state_r == PVIC_ST_JUMP)
                            && (cnt_r == `PVIC_LONG_JUMP_OP_CYC - `PVIC_CNT_ONE);
            dispatchBusy <= (state_r != PVIC_ST_IDLE);
            irqRequest   <= globalIrqEnable && (pickNow != `PVIC_PRIO_NONE);
            vectorLow    <= {1'b0, selPrio_r, 2'b00};
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic inDisp;
    logic inJump;
    assign inDisp = (state_r == PVIC_ST_DISP);
    assign inJump = (state_r == PVIC_ST_JUMP);

    property p_posted_set;
        (|hwSet) |=> ((posted_r & $past(hwSet)) == $past(hwSet));
    endproperty
    a_posted_set: assert property (p_posted_set) else $error("event not posted");

    property p_sw_clear;
        (|swClear && !(|(hwSet & swClear))) |=> ((posted_r & $past(swClear)) == 24'h0);
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("clear write lost");

    property p_sw_post;
        (|swPost) |-> swPostEnable_r ##1 ((posted_r & $past(swPost)) == $past(swPost));
    endproperty
    a_sw_post: assert property (p_sw_post) else $error("software post wrong");

    property p_req_gated;
        irqRequest |-> $past(globalIrqEnable) && $past(|(posted_r & mask_r));
    endproperty
    a_req_gated: assert property (p_req_gated) else $error("request not gated");

    property p_take_gie;
        $rose(inDisp) |-> $past(globalIrqEnable) && $past(instrDone || retPending_r);
    endproperty
    a_take_gie: assert property (p_take_gie) else $error("dispatch without enable");

    property p_disp_len;
        $rose(inDisp) |-> ##12 inDisp ##1 inJump;
    endproperty
    a_disp_len: assert property (p_disp_len) else $error("dispatch not 13 cycles");

    property p_push_order;
        $rose(inDisp) |=> pushPcHigh ##1 pushPcLow ##1 pushFlags ##1 clearFlags ##1 loadVector;
    endproperty
    a_push_order: assert property (p_push_order) else $error("stacking order wrong");

    property p_jump_len;
        $rose(inJump) |-> ##7 isrEntry;
    endproperty
    a_jump_len: assert property (p_jump_len) else $error("isr entry late");

    property p_vector;
        loadVector |-> (vectorLow[1:0] == 2'b00) && (vectorLow[6:2] != 5'h00)
                       && (vectorLow[6:2] < 5'h16 || vectorLow[6:2] == 5'h19);
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");

endmodule : pvic_ctrl

`default_nettype wire

// ==== dv/pvic_cpu_model.sv ====
/* cpu core model facing the interrupt controller: instruction boundaries,
   global enable flag, stacking of the flag and the return.
   assumes the bench picks the instruction length and asks for returns. */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// cpu core model
module pvic_cpu_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // bench control
    input  wire logic [3:0] instrLen,
    input  wire logic       gieSet,
    input  wire logic       doReturn,
    // controller side
    input  wire logic       dispatchBusy,
    input  wire logic       clearFlags,
    output logic            globalIrqEnable,
    output logic            instrDone,
    output logic            returnFromIrqOp
);
    logic [3:0] cnt_r;
    logic       gieSaved_r;

    // no boundary while stacked, so a take only ever follows a finished instruction or a return
    always_ff @(posedge clock) begin
        if (!reset_n || dispatchBusy) begin
            cnt_r     <= 4'h0;
            instrDone <= 1'b0;
        end else begin
            instrDone <= (cnt_r == instrLen);
            cnt_r     <= (cnt_r == instrLen) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            globalIrqEnable <= 1'b0;
            gieSaved_r      <= 1'b0;
            returnFromIrqOp <= 1'b0;
        end else begin
            returnFromIrqOp <= doReturn;
            if (clearFlags) begin
                gieSaved_r      <= globalIrqEnable;
                globalIrqEnable <= 1'b0;
            end else if (doReturn) begin
                globalIrqEnable <= gieSaved_r;
            end else if (gieSet) begin
                globalIrqEnable <= 1'b1;
            end
        end
    end
endmodule : pvic_cpu_model

`default_nettype wire

// ==== dv/tb.sv ====
/* self-checking bench of the interrupt controller: registers, posting,
   masking, priority and dispatch. assumes the design and cpu model files. */
`timescale 1ns/1ps
`default_nettype none
`include "pvic_defs.svh"

// ==========================================================
// bench
module tb;
    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] srcEvent, fl;
    logic [3:0]  gpioPin, instrLen;
    logic        usbDp, usbDm, globalIrqEnable, instrDone, returnFromIrqOp, ps2Pad, slowClk;
    logic        gieSet, doReturn, irqRequest, dispatchBusy, isrEntry;
    logic        pushPcHigh, pushPcLow, pushFlags, clearFlags, loadVector;
    logic [7:0]  vectorLow, rd;
    int          failures, num_checks, cyc, b;
    logic [9:0]  regs [7] = '{`PVIC_IDX_CLR0, `PVIC_IDX_CLR1, `PVIC_IDX_CLR2,
        `PVIC_IDX_MSK3, `PVIC_IDX_MSK2, `PVIC_IDX_MSK0, `PVIC_IDX_MSK1};

    pvic_ctrl i_pvic_ctrl (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .srcEvent, .gpioPin, .usbDp, .usbDm,
        .ps2DataPad(ps2Pad), .ps2PadIsInput(1'b1), .clk32k(slowClk), .globalIrqEnable,
        .instrDone, .returnFromIrqOp, .irqRequest, .dispatchBusy, .pushPcHigh,
        .pushPcLow, .pushFlags, .clearFlags, .loadVector, .vectorLow, .isrEntry);
    pvic_cpu_model i_pvic_cpu_model (.clock, .reset_n, .instrLen, .gieSet,
        .doReturn, .dispatchBusy, .clearFlags, .globalIrqEnable, .instrDone,
        .returnFromIrqOp);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    function automatic int prio(input int s);
        case (s)
            5: return 7;
            6: return 25;
            7: return 6;
            default: return (s < 5) ? s + 1 : s;
        endcase
    endfunction : prio

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // ==========================================================
    // apb master: request held until pready is sampled
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clock) penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdflags();
        apb(1'b0, `PVIC_IDX_CLR0, 8'h00);
        fl[7:0] = rd;
        apb(1'b0, `PVIC_IDX_CLR1, 8'h00);
        fl[15:8] = rd;
        apb(1'b0, `PVIC_IDX_CLR2, 8'h00);
        fl[23:16] = rd;
    endtask : rdflags

    task automatic wrchk(input logic [9:0] idx, input logic [7:0] wd, input logic [23:0] e);
        apb(1'b1, idx, wd);
        rdflags();
        chk(fl, e);
    endtask : wrchk

    task automatic post(input logic [23:0] v);
        @(posedge clock) srcEvent <= v;
        @(posedge clock) srcEvent <= 24'h0;
    endtask : post

    // strobes are pulses, so each is looked at in its own cycle
    task automatic seq(input int s, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (pushPcHigh !== 1'b1 && n < lim);
        chk(24'(n < lim), 24'h1);
        @(negedge clock) chk(24'(pushPcLow), 24'h1);
        @(negedge clock) chk(24'(pushFlags), 24'h1);
        @(negedge clock) chk(24'(clearFlags), 24'h1);
        @(negedge clock) chk(24'(loadVector), 24'h1);
        chk(24'(dispatchBusy), 24'h1);
        chk(24'(vectorLow), 24'(prio(s) * 4));
        repeat (15) @(negedge clock);
        chk(24'(isrEntry), 24'h1);
    endtask : seq

    // return just after a boundary, so the next boundary is far away
    task automatic ret();
        int n;
        n = 0;
        @(posedge clock) instrLen <= 4'hf;
        do begin
            @(negedge clock);
            n++;
        end while (instrDone !== 1'b1 && n < 40);
        @(posedge clock) doReturn <= 1'b1;
        @(posedge clock) doReturn <= 1'b0;
    endtask : ret

    task automatic disp(input int a, input int c);
        int w, l;
        w = (prio(a) < prio(c)) ? a : c;
        l = (w == a) ? c : a;
        @(posedge clock) instrLen <= 4'($urandom_range(4, 0));
        post((24'h1 << a) | (24'h1 << c));
        seq(w, 60);
        rdflags();
        chk(fl, (a == c) ? 24'h0 : 24'h1 << l);
        ret();
        if (a != c) begin
            seq(l, 8);
            ret();
        end
    endtask : disp

    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cyc++;
        slowClk <= cyc[2]; // scaled slow clock: one rising edge every 8 cycles
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, srcEvent} = '0;
        {gpioPin, gieSet, doReturn, usbDp} = '0;
        {usbDm, ps2Pad} = 2'b11;
        instrLen = 4'h2;
        void'($urandom(32'h4a99c8d7));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 8'h00);
            chk({rd, 15'h0, err}, 24'h0);
        end
        apb(1'b0, 10'h0dd, 8'h00);
        chk({rd, 15'h0, err}, 24'h1);
        $display("test reset and unmapped done");
        repeat (6) begin
            b = $urandom_range(21, 0);
            post(24'h1 << b);
            wrchk(`PVIC_IDX_CLR0 + 10'(b / 8), 8'hff, 24'h1 << b);
            wrchk(`PVIC_IDX_CLR0 + 10'(b / 8), 8'h00, 24'h0);
            apb(1'b1, `PVIC_IDX_MSK3, 8'h80);
            wrchk(`PVIC_IDX_CLR0 + 10'(b / 8), 8'h00, 24'h0);
            wrchk(`PVIC_IDX_CLR0 + 10'(b / 8), 8'h1 << (b % 8), 24'h1 << b);
            apb(1'b1, `PVIC_IDX_MSK3, 8'h00);
            wrchk(`PVIC_IDX_CLR0 + 10'(b / 8), 8'h00, 24'h0);
        end
        $display("test post and clear done");
        @(posedge clock) gpioPin <= 4'h2;
        repeat (6) @(posedge clock);
        wrchk(`PVIC_IDX_CLR1, 8'h00, 24'h80);
        wrchk(`PVIC_IDX_CLR0, 8'h00, 24'h0);
        @(posedge clock) {usbDp, usbDm} <= 2'b10;
        repeat (6) @(posedge clock);
        wrchk(`PVIC_IDX_CLR1, 8'hff, 24'h1000);
        wrchk(`PVIC_IDX_CLR1, 8'h00, 24'h0);
        @(posedge clock) ps2Pad <= 1'b0;
        repeat (70) @(posedge clock);
        ps2Pad <= 1'b1;
        wrchk(`PVIC_IDX_CLR2, 8'hff, 24'h80000);
        wrchk(`PVIC_IDX_CLR2, 8'h00, 24'h0);
        $display("test pin sources done");
        post(24'h1 << 13);
        wrchk(`PVIC_IDX_MSK3, 8'h00, 24'h2000);
        chk(24'(irqRequest), 24'h0);
        foreach (regs[i]) if (i > 3) apb(1'b1, regs[i], 8'hff);
        repeat (3) @(negedge clock);
        chk(24'(irqRequest), 24'h0);
        @(posedge clock) gieSet <= 1'b1;
        @(posedge clock) gieSet <= 1'b0;
        repeat (2) @(negedge clock);
        chk(24'(irqRequest), 24'h1);
        seq(13, 20);
        ret();
        for (int i = 0; i < 22; i++) disp(i, i);
        repeat (6) disp($urandom_range(21, 0), $urandom_range(21, 0));
        $display("test dispatch done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
